// [inc/twspc_regs.vh]
`ifndef TWSPC_REGS_VH
`define TWSPC_REGS_VH

// Register addresses
`define TW_A_DAT 8'hbc
`define TW_A_STAT 8'hbd
`define TW_A_CLK 8'hbe
`define TW_A_TMR 8'hbf
`define TW_A_CON 8'hc0
`define TW_A_ADR 8'hc1
// Bit positions
`define TW_B_EN 6
`define TW_B_START 5
`define TW_B_STOP 4
`define TW_B_EVT 3
`define TW_B_ACK 2
`define TW_B_TEN 2
`define TW_B_TFLAG 0
`define TW_B_GCALL 0
`define TW_TO_W 14
// Status codes
`define TW_S_START 8'h08
`define TW_S_RSTART 8'h10
`define TW_S_MTAW_A 8'h18
`define TW_S_MTAW_N 8'h20
`define TW_S_MTD_A 8'h28
`define TW_S_MTD_N 8'h30
`define TW_S_LOST 8'h38
`define TW_S_MRAR_A 8'h40
`define TW_S_MRAR_N 8'h48
`define TW_S_MRD_A 8'h50
`define TW_S_MRD_N 8'h58
`define TW_S_SRAW 8'h60
`define TW_S_SRAW_L 8'h68
`define TW_S_SRGC 8'h70
`define TW_S_SRGC_L 8'h78
`define TW_S_SRD_A 8'h80
`define TW_S_SRD_N 8'h88
`define TW_S_GCD_A 8'h90
`define TW_S_GCD_N 8'h98
`define TW_S_SSTOP 8'ha0
`define TW_S_STAR 8'ha8
`define TW_S_STAR_L 8'hb0
`define TW_S_STD_A 8'hb8
`define TW_S_STD_N 8'hc0
`define TW_S_STLAST 8'hc8
`define TW_S_IDLE 8'hf8
`endif

// [hdl/twspc_core.v]
`timescale 1ns/1ns
`include "twspc_regs.vh"
module twspc_core #(
    parameter TO_W = `TW_TO_W
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    input wire global_int_enable_in,
    input wire port_int_enable_in,
    output wire int_req_out,
    input wire scl_in,
    output wire scl_out,
    output reg scl_oe_out,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_out
);
    // Master line sequencer states
    localparam M_IDLE = 4'd0;
    localparam M_START = 4'd1;
    localparam M_HOLD = 4'd2;
    localparam M_LOW = 4'd3;
    localparam M_HIGH = 4'd4;
    localparam M_STP_A = 4'd5;
    localparam M_STP_B = 4'd6;
    localparam M_STP_C = 4'd7;
    localparam M_RS_A = 4'd8;
    localparam M_RS_B = 4'd9;

    reg scl_s, sda_s, scl_p, sda_p;
    reg port_enable, start_request, stop_request, event_flag, assert_ack;
    reg general_call_enable, timeout_enable, timeout_flag;
    reg [6:0] own_addr;
    reg [7:0] bit_rate_divider, shift_data, code, status_vis;
    reg ack_bit, tx_bit, tx_dir, is_addr, byte_act, master, arb;
    reg addressed, gcall_hit, slave_tx, rs_flag, bus_busy;
    reg [3:0] bit_cnt, ms, ms_d;
    reg [7:0] q_cnt;
    reg [1:0] q_n;
    reg [TO_W-1:0] to_cnt;

    // Selects the code for an acknowledged or refused byte
    function [7:0] pick;
        input sel;
        input [7:0] a;
        input [7:0] b;
        begin
            pick = sel ? a : b;
        end
    endfunction

    // Bus events from sampled pins
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
    wire got_ack = ~ack_bit;
    wire wr_con = sfr_wr_in & (sfr_addr_in == `TW_A_CON);
    wire flag_clr = wr_con & ~sfr_wdata_in[`TW_B_EVT] & event_flag;
    wire eng = port_enable & byte_act & ~event_flag;
    // Address recognition
    wire own_hit = (shift_data[7:1] == own_addr);
    wire gcall_w = general_call_enable & (shift_data[7:1] == 7'h00);
    wire match = own_hit | gcall_w;
    // Quarter-bit timebase, paused while the clock line is held low in a high phase
    wire high_ph = (ms == M_HIGH) | (ms == M_RS_B) | (ms == M_STP_B) | (ms == M_START);
    wire q_run = ~high_ph | scl_s;
    wire tick = (ms == ms_d) & q_run & (q_cnt == bit_rate_divider);
    wire q2 = tick & q_n[0];
    wire m_scl_low = (ms == M_HOLD) | (ms == M_LOW) | (ms == M_STP_A) | (ms == M_RS_A);
    wire m_sda_low = (ms == M_START) | (ms == M_STP_A) | (ms == M_STP_B);

    // Open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign int_req_out = global_int_enable_in & port_int_enable_in & (event_flag | timeout_flag);

    // Pin sampling
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_s <= 1'b1;
            sda_s <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_s <= scl_in;
            sda_s <= sda_in;
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    // Registers, master sequencer and byte engine
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_enable <= 1'b0;
            start_request <= 1'b0;
            stop_request <= 1'b0;
            event_flag <= 1'b0;
            assert_ack <= 1'b0;
            general_call_enable <= 1'b0;
            timeout_enable <= 1'b0;
            timeout_flag <= 1'b0;
            own_addr <= 7'h00;
            bit_rate_divider <= 8'h00;
            shift_data <= 8'h00;
            code <= `TW_S_IDLE;
            ack_bit <= 1'b1;
            tx_bit <= 1'b1;
            tx_dir <= 1'b0;
            is_addr <= 1'b0;
            byte_act <= 1'b0;
            master <= 1'b0;
            arb <= 1'b0;
            addressed <= 1'b0;
            gcall_hit <= 1'b0;
            slave_tx <= 1'b0;
            rs_flag <= 1'b0;
            bus_busy <= 1'b0;
            bit_cnt <= 4'd0;
            ms <= M_IDLE;
            ms_d <= M_IDLE;
            q_cnt <= 8'h00;
            q_n <= 2'd0;
            to_cnt <= {TO_W{1'b0}};
        end else begin
            // Timebase restarts on every sequencer state change
            ms_d <= ms;
            if (ms != ms_d) begin
                q_cnt <= 8'h00;
                q_n <= 2'd0;
            end else if (tick) begin
                q_cnt <= 8'h00;
                q_n <= q_n + 2'd1;
            end else if (q_run) begin
                q_cnt <= q_cnt + 8'd1;
            end
            // CPU writes
            if (sfr_wr_in) begin
                case (sfr_addr_in)
                    `TW_A_CON: begin
                        port_enable <= sfr_wdata_in[`TW_B_EN];
                        start_request <= sfr_wdata_in[`TW_B_START];
                        stop_request <= sfr_wdata_in[`TW_B_STOP];
                        assert_ack <= sfr_wdata_in[`TW_B_ACK];
                        if (!sfr_wdata_in[`TW_B_EVT])
                            event_flag <= 1'b0;
                    end
                    `TW_A_DAT: if (event_flag) shift_data <= sfr_wdata_in;
                    `TW_A_CLK: bit_rate_divider <= sfr_wdata_in;
                    `TW_A_TMR: begin
                        timeout_enable <= sfr_wdata_in[`TW_B_TEN];
                        if (!sfr_wdata_in[`TW_B_TFLAG])
                            timeout_flag <= 1'b0;
                    end
                    `TW_A_ADR: begin
                        own_addr <= sfr_wdata_in[7:1];
                        general_call_enable <= sfr_wdata_in[`TW_B_GCALL];
                    end
                    default: ;
                endcase
            end
            // Bus free tracking
            if (start_det)
                bus_busy <= 1'b1;
            else if (stop_det)
                bus_busy <= 1'b0;
            if (!port_enable) begin
                // Disabled port: idle, pins released
                stop_request <= 1'b0;
                ms <= M_IDLE;
                master <= 1'b0;
                byte_act <= 1'b0;
                addressed <= 1'b0;
                arb <= 1'b0;
                tx_bit <= 1'b1;
                bit_cnt <= 4'd0;
                to_cnt <= {TO_W{1'b0}};
            end else begin
                // Time-out counter runs while enabled and the event flag is clear
                if (timeout_enable && !event_flag) begin
                    to_cnt <= to_cnt + 1'b1;
                    if (&to_cnt)
                        timeout_flag <= 1'b1;
                end else begin
                    to_cnt <= {TO_W{1'b0}};
                end
                // START seen as slave
                if (start_det && !master) begin
                    if (addressed) begin
                        event_flag <= 1'b1;
                        code <= `TW_S_SSTOP;
                        addressed <= 1'b0;
                        byte_act <= 1'b0;
                    end else if (!event_flag) begin
                        byte_act <= 1'b1;
                        is_addr <= 1'b1;
                        tx_dir <= 1'b0;
                        bit_cnt <= 4'd0;
                        tx_bit <= 1'b1;
                    end
                end
                // STOP seen on the bus
                if (stop_det) begin
                    stop_request <= 1'b0;
                    if (!master) begin
                        byte_act <= 1'b0;
                        if (addressed) begin
                            event_flag <= 1'b1;
                            code <= `TW_S_SSTOP;
                            addressed <= 1'b0;
                        end
                    end
                end
                // Slave abandons the transfer on request
                if (stop_request && !master && ms == M_IDLE) begin
                    addressed <= 1'b0;
                    byte_act <= 1'b0;
                    stop_request <= 1'b0;
                    tx_bit <= 1'b1;
                end
                // First bit of the next byte goes out when the flag clears
                if (flag_clr)
                    tx_bit <= ~(byte_act & tx_dir) | shift_data[7];
                // Master sequencer
                case (ms)
                    M_IDLE: if (start_request && !bus_busy && !addressed && !event_flag) begin
                        ms <= M_START;
                        master <= 1'b1;
                        rs_flag <= 1'b0;
                    end
                    M_START: if (q2) begin
                        ms <= M_HOLD;
                        event_flag <= 1'b1;
                        code <= rs_flag ? `TW_S_RSTART : `TW_S_START;
                        byte_act <= 1'b1;
                        is_addr <= 1'b1;
                        tx_dir <= 1'b1;
                        bit_cnt <= 4'd0;
                        tx_bit <= 1'b0;
                        arb <= 1'b0;
                    end
                    M_HOLD: if (!event_flag) begin
                        if (stop_request) begin
                            ms <= M_STP_A;
                            byte_act <= 1'b0;
                        end else if (start_request) begin
                            ms <= M_RS_A;
                            byte_act <= 1'b0;
                        end else begin
                            ms <= M_LOW;
                        end
                    end
                    M_LOW: if (q2) ms <= M_HIGH;
                    M_HIGH: if (q2) ms <= M_LOW;
                    M_STP_A: if (tick) ms <= M_STP_B;
                    M_STP_B: if (q2) ms <= M_STP_C;
                    M_STP_C: if (q2) begin
                        ms <= M_IDLE;
                        master <= 1'b0;
                    end
                    M_RS_A: if (tick) ms <= M_RS_B;
                    M_RS_B: if (q2) begin
                        ms <= M_START;
                        rs_flag <= 1'b1;
                    end
                    default: ms <= M_IDLE;
                endcase
                // Rising clock: sample data or acknowledge, check arbitration
                if (eng && scl_rise) begin
                    if (bit_cnt[3])
                        ack_bit <= sda_s;
                    else
                        shift_data <= {shift_data[6:0], sda_s};
                    if (master && tx_dir && tx_bit && !sda_s && !bit_cnt[3]) begin
                        master <= 1'b0;
                        arb <= 1'b1;
                        tx_dir <= 1'b0;
                        ms <= M_IDLE;
                    end
                    bit_cnt <= bit_cnt + 4'd1;
                end
                // Falling clock: next bit, acknowledge, or byte done
                if (eng && scl_fall) begin
                    if (bit_cnt == 4'd8) begin
                        tx_bit <= tx_dir | ~(assert_ack & (master | (is_addr ? match : addressed)));
                    end else if (bit_cnt == 4'd9) begin
                        tx_bit <= 1'b1;
                        bit_cnt <= 4'd0;
                        is_addr <= 1'b0;
                        arb <= 1'b0;
                        event_flag <= 1'b1;
                        byte_act <= 1'b1;
                        if (master) begin
                            ms <= M_HOLD;
                            if (is_addr) begin
                                tx_dir <= ~shift_data[0];
                                code <= shift_data[0] ? pick(got_ack, `TW_S_MRAR_A, `TW_S_MRAR_N)
                                    : pick(got_ack, `TW_S_MTAW_A, `TW_S_MTAW_N);
                            end else if (tx_dir) begin
                                code <= pick(got_ack, `TW_S_MTD_A, `TW_S_MTD_N);
                            end else begin
                                code <= pick(got_ack, `TW_S_MRD_A, `TW_S_MRD_N);
                            end
                        end else if (is_addr) begin
                            if (match && got_ack) begin
                                addressed <= 1'b1;
                                gcall_hit <= ~own_hit;
                                slave_tx <= shift_data[0];
                                tx_dir <= shift_data[0];
                                code <= shift_data[0] ? pick(arb, `TW_S_STAR_L, `TW_S_STAR)
                                    : own_hit ? pick(arb, `TW_S_SRAW_L, `TW_S_SRAW)
                                    : pick(arb, `TW_S_SRGC_L, `TW_S_SRGC);
                            end else begin
                                byte_act <= 1'b0;
                                event_flag <= arb;
                                code <= `TW_S_LOST;
                            end
                        end else if (!addressed) begin
                            byte_act <= 1'b0;
                            code <= `TW_S_LOST;
                        end else if (slave_tx) begin
                            code <= ack_bit ? `TW_S_STD_N : pick(assert_ack, `TW_S_STD_A, `TW_S_STLAST);
                            if (ack_bit || !assert_ack) begin
                                addressed <= 1'b0;
                                byte_act <= 1'b0;
                            end
                        end else begin
                            code <= gcall_hit ? pick(got_ack, `TW_S_GCD_A, `TW_S_GCD_N)
                                : pick(got_ack, `TW_S_SRD_A, `TW_S_SRD_N);
                            if (ack_bit) begin
                                addressed <= 1'b0;
                                byte_act <= 1'b0;
                            end
                        end
                    end else if (bit_cnt != 4'd0) begin
                        tx_bit <= ~tx_dir | shift_data[7];
                    end
                end
            end
        end
    end

    // Status view, pin drivers and read data
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_vis <= `TW_S_IDLE;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            sfr_rdata_out <= 8'h00;
        end else begin
            status_vis <= event_flag ? {code[7:3], 3'b000} : `TW_S_IDLE;
            sda_oe_out <= port_enable & (m_sda_low | (byte_act & ~tx_bit));
            scl_oe_out <= port_enable & (m_scl_low | (event_flag & addressed & ~master));
            case (sfr_addr_in)
                `TW_A_CON: sfr_rdata_out <= {1'b0, port_enable, start_request, stop_request,
                    event_flag, assert_ack, 2'b00};
                `TW_A_STAT: sfr_rdata_out <= status_vis;
                `TW_A_DAT: sfr_rdata_out <= shift_data;
                `TW_A_CLK: sfr_rdata_out <= bit_rate_divider;
                `TW_A_TMR: sfr_rdata_out <= {5'b00000, timeout_enable, 1'b0, timeout_flag};
                `TW_A_ADR: sfr_rdata_out <= {own_addr, general_call_enable};
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // twspc_core

// [sim/twspc_assertions.sv]
`timescale 1ns/1ns
// Port-level checker for the two-wire port controller
module twspc_checker #(
    parameter TO_W = 14
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire [7:0] sfr_wdata_in,
    input wire [7:0] sfr_rdata_out,
    input wire global_int_enable_in,
    input wire port_int_enable_in,
    input wire int_req_out,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe_out,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out
);
    reg [7:0] div_q;
    reg [7:0] hi_cnt;
    // Track the divider and how long the clock line has been released
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 8'h00;
            hi_cnt <= 8'h00;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'hbe) begin
                div_q <= sfr_wdata_in;
            end
            hi_cnt <= scl_oe_out ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Control write that turns the port off, then a quiet look at control
    sequence s_ctl_off;
        sfr_wr_in && sfr_addr_in == 8'hc0 && !sfr_wdata_in[6];
    endsequence
    sequence s_ctl_view;
        sfr_addr_in == 8'hc0 && !sfr_wr_in;
    endsequence
    a_status_low_zero:
        assert property ($past(sfr_addr_in) == 8'hbd |-> sfr_rdata_out[2:0] == 3'b000) else $error("status low bits set");
    a_int_gated:
        assert property (int_req_out |-> global_int_enable_in && port_int_enable_in) else $error("interrupt not gated");
    a_flag_raises_int:
        assert property ($past(sfr_addr_in) == 8'hc0 && sfr_rdata_out[3] && $past(global_int_enable_in)
            && $past(port_int_enable_in) |-> $past(int_req_out)) else $error("flag without interrupt");
    a_flag_kept:
        assert property (($past(sfr_addr_in) == 8'hc0 && !$past(sfr_wr_in) && sfr_rdata_out[3]) and s_ctl_view
            |=> sfr_rdata_out[3]) else $error("event flag cleared by hardware");
    a_stop_dropped:
        assert property (s_ctl_off ##1 s_ctl_view ##1 s_ctl_view |=> !sfr_rdata_out[4])
            else $error("stop request kept when off");
    a_off_quiet:
        assert property (s_ctl_off |-> ##[2:3] !scl_oe_out && !sda_oe_out) else $error("lines driven when off");
    a_rise_no_data:
        assert property ($rose(scl_in) |-> $stable(sda_oe_out)) else $error("data changed at clock rise");
    a_high_phase:
        assert property ($rose(scl_oe_out) |-> {1'b0, hi_cnt} >= {div_q, 1'b1}) else $error("clock high too short");
endmodule // twspc_checker

bind twspc_core twspc_checker #(.TO_W(TO_W)) u_twspc_checker (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .global_int_enable_in(global_int_enable_in), .port_int_enable_in(port_int_enable_in),
    .int_req_out(int_req_out), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

// [sim/twspc_slave_model.sv]
`timescale 1ns/1ns
// Behavioural slave on the far side of the two-wire bus
module twspc_slave_model #(
    parameter [6:0] ADDR = 7'h2a
) (
    input wire ref_clk_in,
    input wire scl_in,
    input wire sda_in,
    input wire nack_in,
    input wire [7:0] stretch_in,
    output reg scl_pull_out,
    output reg sda_pull_out,
    output reg [7:0] last_byte_out
);
    reg [7:0] shift;
    reg hit;
    reg first;
    integer i;
    // Ninth clock: stretch the low phase, set the answer, then free the clock
    task ack_bit(input reg ack);
        begin
            @(negedge scl_in);
            scl_pull_out = 1'b1;
            repeat (stretch_in) @(posedge ref_clk_in);
            #1 sda_pull_out = ack;
            @(posedge ref_clk_in);
            #1 scl_pull_out = 1'b0;
            @(negedge scl_in);
            sda_pull_out = 1'b0;
        end
    endtask
    // Frame receiver, restarted at a START that follows a STOP or a refused address
    initial begin
        scl_pull_out = 1'b0;
        sda_pull_out = 1'b0;
        last_byte_out = 8'h00;
        shift = 8'h00;
        forever begin : rx
            @(negedge sda_in iff scl_in === 1'b1);
            first = 1'b1;
            hit = 1'b1;
            while (hit) begin
                for (i = 0; i < 8; i = i + 1) begin
                    @(posedge scl_in);
                    shift = {shift[6:0], sda_in};
                end
                if (first) begin
                    hit = (shift[7:1] == ADDR) && !shift[0];
                end else begin
                    last_byte_out = shift;
                end
                ack_bit(first ? hit : !nack_in);
                first = 1'b0;
            end
        end
    end
    // STOP ends the frame and frees both lines
    always @(posedge sda_in) begin
        if (scl_in === 1'b1) begin
            disable rx;
            sda_pull_out = 1'b0;
            scl_pull_out = 1'b0;
        end
    end
endmodule // twspc_slave_model

// [sim/twspc_core_bench.sv]
`timescale 1ns/1ns
`include "twspc_regs.vh"
module twspc_core_bench;
    localparam TOW = 4;
    localparam [6:0] PEER = 7'h2a;
    reg ref_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [7:0] addr = 8'h00;
    reg wr = 1'b0;
    reg [7:0] wdata = 8'h00;
    reg gie = 1'b1;
    reg pie = 1'b1;
    reg nack = 1'b0;
    reg [7:0] v;
    wire [7:0] rdata;
    wire [7:0] peer_byte;
    wire int_req, scl_oe, sda_oe, scl_pull, sda_pull;
    wire scl_o, sda_o;
    integer errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    // Open-drain lines with pull-ups, idle high
    wire scl_w = !(scl_oe || scl_pull);
    wire sda_w = !(sda_oe || sda_pull);
    twspc_core #(.TO_W(TOW)) u_twspc_core (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .global_int_enable_in(gie),
        .port_int_enable_in(pie), .int_req_out(int_req), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe));
    twspc_slave_model #(.ADDR(PEER)) u_twspc_slave_model (.ref_clk_in(ref_clk_in), .scl_in(scl_w), .sda_in(sda_w),
        .nack_in(nack), .stretch_in(8'h28), .scl_pull_out(scl_pull), .sda_pull_out(sda_pull),
        .last_byte_out(peer_byte));
    always #4 ref_clk_in = ~ref_clk_in;
    // Cycle limit against hangs
    always @(posedge ref_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            $display("ERROR at %0t: run too long", $time);
            results;
        end
    end
    task results;
        begin
            $display("errors=%0d comparisons=%0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk_in) #1 addr = a;
            wdata = d;
            wr = 1'b1;
            @(posedge ref_clk_in) #1 wr = 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, output [7:0] d);
        begin
            @(posedge ref_clk_in) #1 addr = a;
            @(posedge ref_clk_in) #1 d = rdata;
        end
    endtask
    // Poll one control bit until it reaches the wanted level
    task wait_c0(input integer b, input reg lvl);
        integer n;
        begin
            n = 0;
            rd_reg(`TW_A_CON, v);
            while (v[b] !== lvl && n < 600) begin
                rd_reg(`TW_A_CON, v);
                n = n + 1;
            end
            check({7'h00, v[b]}, {7'h00, lvl});
        end
    endtask
    task send(input [7:0] d, input [7:0] ctl, input [7:0] code);
        begin
            wr_reg(`TW_A_DAT, d);
            wr_reg(`TW_A_CON, ctl);
            wait_c0(`TW_B_EVT, 1'b1);
            rd_reg(`TW_A_STAT, v);
            check(v, code);
        end
    endtask
    task stop_bus;
        begin
            wr_reg(`TW_A_CON, 8'h54);
            wait_c0(`TW_B_STOP, 1'b0);
            rd_reg(`TW_A_STAT, v);
            check(v, `TW_S_IDLE);
            check({6'h00, scl_w, sda_w}, 8'h03);
        end
    endtask
    task t_reset;
        begin
            rd_reg(`TW_A_STAT, v);
            check(v, `TW_S_IDLE);
            rd_reg(`TW_A_CON, v);
            check(v, 8'h00);
            rd_reg(8'hc2, v);
            check(v, 8'h00);
            check({6'h00, scl_o, sda_o}, 8'h00);
        end
    endtask
    task t_timeout;
        begin
            wr_reg(`TW_A_CON, 8'h40);
            wr_reg(`TW_A_TMR, 8'h04);
            repeat ((1 << TOW) + 4) @(posedge ref_clk_in);
            rd_reg(`TW_A_TMR, v);
            check(v, 8'h05);
            check({7'h00, int_req}, 8'h01);
            wr_reg(`TW_A_TMR, 8'h00);
            rd_reg(`TW_A_TMR, v);
            check(v, 8'h00);
        end
    endtask
    task t_master_write;
        begin
            wr_reg(`TW_A_CLK, 8'h03);
            wr_reg(`TW_A_CON, 8'h64);
            wait_c0(`TW_B_EVT, 1'b1);
            rd_reg(`TW_A_STAT, v);
            check(v, `TW_S_START);
            send({PEER, 1'b0}, 8'h44, `TW_S_MTAW_A);
            wr_reg(`TW_A_DAT, 8'ha5);
            wr_reg(`TW_A_CON, 8'h44);
            wr_reg(`TW_A_DAT, 8'h3c);
            wait_c0(`TW_B_EVT, 1'b1);
            rd_reg(`TW_A_STAT, v);
            check(v, `TW_S_MTD_A);
            rd_reg(`TW_A_DAT, v);
            check(v, 8'ha5);
            check(peer_byte, 8'ha5);
            check({7'h00, int_req}, 8'h01);
            @(posedge ref_clk_in) #1 gie = 1'b0;
            @(posedge ref_clk_in) #1 check({7'h00, int_req}, 8'h00);
            gie = 1'b1;
            nack = 1'b1;
            send(8'h5a, 8'h44, `TW_S_MTD_N);
            nack = 1'b0;
            stop_bus;
        end
    endtask
    task t_absent_restart;
        begin
            wr_reg(`TW_A_CON, 8'h64);
            wait_c0(`TW_B_EVT, 1'b1);
            send({7'h11, 1'b0}, 8'h44, `TW_S_MTAW_N);
            wr_reg(`TW_A_CON, 8'h64);
            wait_c0(`TW_B_EVT, 1'b1);
            send({7'h00, 1'b0}, 8'h40, `TW_S_MTAW_N);
            wr_reg(`TW_A_CON, 8'h64);
            wait_c0(`TW_B_EVT, 1'b1);
            rd_reg(`TW_A_STAT, v);
            check(v, `TW_S_RSTART);
            send({PEER, 1'b0}, 8'h44, `TW_S_MTAW_A);
            stop_bus;
        end
    endtask
    task t_disable;
        begin
            wr_reg(`TW_A_CON, 8'h10);
            rd_reg(`TW_A_CON, v);
            check(v, 8'h00);
            rd_reg(`TW_A_CON, v);
            check(v, 8'h00);
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        t_reset;
        t_timeout;
        t_master_write;
        t_absent_restart;
        t_disable;
        results;
    end
endmodule // twspc_core_bench
